// ===== rftag_pkg.sv
// Constants and types for the RF tag state and request-flag controller.
// Assumes a 50 MHz system clock and a 32-bit AXI4-Lite register bus.
package rftag_pkg;

  // ==========================================================
  // Clock and protocol states
  localparam int unsigned CLK_PERIOD_NS = 20;

  typedef enum logic [3:0] {
    RFTAG_OFF = 4'b0001,
    RFTAG_READY = 4'b0010,
    RFTAG_QUIET = 4'b0100,
    RFTAG_SELECTED = 4'b1000
  } rftag_state_t;

  // ==========================================================
  // Request flag bit positions (bit 1 of the byte is index 0)
  localparam int unsigned FLG_SUBCARRIER = 0;
  localparam int unsigned FLG_DATA_RATE = 1;
  localparam int unsigned FLG_INVENTORY = 2;
  localparam int unsigned FLG_EXTENSION = 3;
  localparam int unsigned FLG_SELECT = 4;
  localparam int unsigned FLG_ADDRESS = 5;
  localparam int unsigned FLG_FAMILY = 4;
  localparam int unsigned FLG_SLOTS = 5;

  localparam logic [7:0] ERR_OPTION = 8'h03;

  // Command codes that move the state or pick a reply format
  localparam logic [7:0] CMD_STAY_QUIET = 8'h02;
  localparam logic [7:0] CMD_SELECT = 8'h25;
  localparam logic [7:0] CMD_RESET_READY = 8'h26;
  localparam logic [7:0] CMD_SYSINFO = 8'h2b;

  // ==========================================================
  // Register map (byte offsets) and fields
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_ID_LO = 8'h08;
  localparam logic [7:0] OFF_ID_HI = 8'h0c;
  localparam logic [7:0] OFF_FAMILY = 8'h10;
  localparam logic [7:0] OFF_REQCNT = 8'h14;
  localparam logic CTRL_EN_RESET = 1'b1;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : rftag_pkg

// ===== rftag_ctrl.sv
// RF tag protocol state machine and request-flag decoder, AXI4-Lite slave.
// Assumes a frame decoder on I_SYS_CLK delivering one request per pulse,
// and an asynchronous field-energy detector on I_FIELD_OK.
//
// Behaviour
// - Four states only: off, ready, quiet, selected; state gates every answer.
// - Off without field energy; enters ready once energy is present.
// - Ready answers requests without the selection-gate bit, ignores those with it unless the addressing bit is set too.
// - Quiet answers addressed and inventory requests, except inventory ones with the slots bit set.
// - Selected answers select-mode, matching addressed and non-addressed requests.
// - Non-addressed non-select request: ready and selected answer, quiet silent.
// - Off again after field absent for the field-loss time.
// - Addressing bit set, selection-gate bit clear: compare serial id, answer on match, silent otherwise.
// - Addressing and selection-gate bits clear: no id present, every tag except a quiet one executes and answers.
// - Selection-gate bit set, addressing bit clear: no id, only a selected tag answers.
// - Eight flag bits; inventory bit 3 picks the meaning of bits 5 to 8.
// - Flag bit 1 picks one or two reply subcarriers.
// - Flag bit 2 picks low or high reply data rate.
// - Flag bit 4 marks the extended protocol format.
// - System information reply is rich with extension bit set, standard otherwise.
// - Without inventory, bit 5 is the selection-gate bit.
// - Without inventory, bit 6 is the addressing bit.
// - With inventory, bit 5 marks an application family field present.
// - With inventory, bit 6 picks one slot when set, sixteen when clear.
// - A request with a failed CRC is dropped without answer.
// - An optional field is present exactly when its flag is set.
//
// The address map and the AXI4-Lite slave port were decided locally.
`timescale 1ns/100ps
`default_nettype none

module rftag_ctrl
  import rftag_pkg::*;
#(
  parameter int unsigned FIELD_LOSS_NS = 1000000,
  parameter logic [63:0] TAG_ID_RESET = 64'h0123_4567_89ab_cdef, // Arbitrary value
  parameter logic [7:0] FAMILY_RESET = 8'h00,
  parameter int unsigned ADDR_W = 8
) (
  input wire logic I_SYS_CLK,
  input wire logic I_RESET,
  input wire logic I_FIELD_OK,
  input wire logic I_REQ_VALID,
  input wire logic I_REQ_CRC_OK,
  input wire logic [7:0] I_REQ_FLAGS,
  input wire logic [7:0] I_REQ_CMD,
  input wire logic [63:0] I_REQ_ID,
  input wire logic [7:0] I_REQ_FAMILY,
  input wire logic [ADDR_W-1:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [ADDR_W-1:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY,
  output logic [3:0] O_STATE,
  output logic O_RSP_VALID,
  output logic O_RSP_ANSWER,
  output logic O_RSP_ERROR,
  output logic [7:0] O_RSP_CODE,
  output logic O_TWO_SUBCARRIERS,
  output logic O_HIGH_RATE,
  output logic O_EXTENDED,
  output logic O_RICH_SYSINFO,
  output logic O_FAMILY_PRESENT,
  output logic O_SINGLE_SLOT
);

  // ==========================================================
  // Field-loss timing
  localparam int unsigned LOSS_RAW = (FIELD_LOSS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned LOSS_CYC = (LOSS_RAW < 1) ? 1 : LOSS_RAW;
  localparam int unsigned LOSS_W = $clog2(LOSS_CYC + 1);
  localparam logic [LOSS_W-1:0] LOSS_LAST = LOSS_W'(LOSS_CYC - 1);

  typedef struct packed {
    logic [2:0] fsync;
    logic field;
    rftag_state_t state;
    logic [LOSS_W-1:0] loss_cnt;
    logic ctrl_en;
    logic [63:0] tag_id;
    logic [7:0] family;
    logic [15:0] req_cnt;
    logic rsp_valid;
    logic rsp_answer;
    logic rsp_error;
    logic [7:0] rsp_code;
    logic two_sub;
    logic high_rate;
    logic extended;
    logic rich_info;
    logic fam_present;
    logic single_slot;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rftag_regs_t;

  rftag_regs_t r;
  rftag_regs_t n;

  // ==========================================================
  // Answer decision: returns {answer, error}
  function automatic logic [1:0] rftag_decide(input rftag_state_t cur, input logic [7:0] f,
                                              input logic id_hit, input logic fam_hit);
    logic ans;
    logic err;
    ans = 1'b0;
    err = 1'b0;
    if (cur == RFTAG_OFF) begin
      ans = 1'b0;
    end else if (f[FLG_INVENTORY]) begin
      if (cur == RFTAG_QUIET && f[FLG_SLOTS]) begin
        ans = 1'b0;
      end else begin
        ans = !f[FLG_FAMILY] || fam_hit;
      end
    end else if (f[FLG_SELECT] && f[FLG_ADDRESS]) begin
      ans = 1'b1;
      err = 1'b1;
    end else if (f[FLG_SELECT]) begin
      ans = (cur == RFTAG_SELECTED);
    end else if (f[FLG_ADDRESS]) begin
      ans = id_hit;
    end else begin
      ans = (cur != RFTAG_QUIET);
    end
    return {ans, err};
  endfunction : rftag_decide

  function automatic logic [31:0] rftag_merge(input logic [31:0] old, input logic [31:0] data,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction : rftag_merge

  function automatic logic [7:0] rftag_word(input logic [ADDR_W-1:0] a);
    return {a[7:2], 2'b00};
  endfunction : rftag_word

  // ==========================================================
  // Next-state logic
  logic id_hit;
  logic fam_hit;
  logic [1:0] verdict;
  logic [31:0] merged;

  assign id_hit = (I_REQ_ID == r.tag_id);
  assign fam_hit = (I_REQ_FAMILY == r.family);
  assign verdict = rftag_decide(r.state, I_REQ_FLAGS, id_hit, fam_hit);

  always_comb begin
    n = r;
    merged = 32'h0000_0000;
    n.fsync = {r.fsync[1:0], I_FIELD_OK};
    if (r.fsync[2] == r.fsync[1]) begin
      n.field = r.fsync[2];
    end
    n.rsp_valid = 1'b0;

    // Field energy supervision
    if (r.field) begin
      n.loss_cnt = '0;
      if (r.state == RFTAG_OFF) begin
        n.state = RFTAG_READY;
      end
    end else if (r.state != RFTAG_OFF) begin
      if (r.loss_cnt == LOSS_LAST) begin
        n.state = RFTAG_OFF;
        n.loss_cnt = '0;
      end else begin
        n.loss_cnt = r.loss_cnt + 1'b1;
      end
    end

    // Request handling; reserved bit 8 and option bit are not looked at
    if (I_REQ_VALID && r.field) begin
      n.rsp_valid = 1'b1;
      n.req_cnt = r.req_cnt + 1'b1;
      n.rsp_answer = verdict[1] && I_REQ_CRC_OK && r.ctrl_en;
      n.rsp_error = verdict[0];
      n.rsp_code = verdict[0] ? ERR_OPTION : 8'h00;
      n.two_sub = I_REQ_FLAGS[FLG_SUBCARRIER];
      n.high_rate = I_REQ_FLAGS[FLG_DATA_RATE];
      n.extended = I_REQ_FLAGS[FLG_EXTENSION];
      n.rich_info = I_REQ_FLAGS[FLG_EXTENSION] && (I_REQ_CMD == CMD_SYSINFO);
      n.fam_present = I_REQ_FLAGS[FLG_INVENTORY] && I_REQ_FLAGS[FLG_FAMILY];
      n.single_slot = I_REQ_FLAGS[FLG_INVENTORY] && I_REQ_FLAGS[FLG_SLOTS];
      if (I_REQ_CRC_OK && r.ctrl_en && r.state != RFTAG_OFF
          && !I_REQ_FLAGS[FLG_INVENTORY] && !verdict[0]) begin
        case (I_REQ_CMD)
          CMD_STAY_QUIET: begin
            if (I_REQ_FLAGS[FLG_ADDRESS] && id_hit) begin
              n.state = RFTAG_QUIET;
            end
          end
          CMD_SELECT: begin
            if (I_REQ_FLAGS[FLG_ADDRESS] && id_hit) begin
              n.state = RFTAG_SELECTED;
            end else if (r.state == RFTAG_SELECTED) begin
              n.state = RFTAG_READY;
            end
          end
          CMD_RESET_READY: begin
            if (verdict[1]) begin
              n.state = RFTAG_READY;
            end
          end
          default: begin
            n.state = n.state;
          end
        endcase
      end
    end

    // AXI4-Lite write: both channels taken together, answer one cycle later
    n.awready = 1'b0;
    n.wready = 1'b0;
    if (r.bvalid && I_BREADY) begin
      n.bvalid = 1'b0;
    end
    if (I_AWVALID && I_WVALID && !r.awready && !r.bvalid) begin
      n.awready = 1'b1;
      n.wready = 1'b1;
    end
    if (r.awready) begin
      n.bvalid = 1'b1;
      n.bresp = RESP_OKAY;
      case (rftag_word(I_AWADDR))
        OFF_CTRL: begin
          merged = rftag_merge({31'h0000_0000, r.ctrl_en}, I_WDATA, I_WSTRB);
          n.ctrl_en = merged[0];
        end
        OFF_ID_LO: begin
          n.tag_id[31:0] = rftag_merge(r.tag_id[31:0], I_WDATA, I_WSTRB);
        end
        OFF_ID_HI: begin
          n.tag_id[63:32] = rftag_merge(r.tag_id[63:32], I_WDATA, I_WSTRB);
        end
        OFF_FAMILY: begin
          merged = rftag_merge({24'h00_0000, r.family}, I_WDATA, I_WSTRB);
          n.family = merged[7:0];
        end
        OFF_STATUS, OFF_REQCNT: begin
          n.bresp = RESP_OKAY;
        end
        default: begin
          n.bresp = RESP_SLVERR;
        end
      endcase
    end

    // AXI4-Lite read: data one cycle after the address is taken
    n.arready = 1'b0;
    if (r.rvalid && I_RREADY) begin
      n.rvalid = 1'b0;
    end
    if (I_ARVALID && !r.arready && !r.rvalid) begin
      n.arready = 1'b1;
    end
    if (r.arready) begin
      n.rvalid = 1'b1;
      n.rresp = RESP_OKAY;
      case (rftag_word(I_ARADDR))
        OFF_CTRL: n.rdata = {31'h0000_0000, r.ctrl_en};
        OFF_STATUS: n.rdata = {25'h000_0000, r.rsp_error, r.rsp_answer, r.field, r.state};
        OFF_ID_LO: n.rdata = r.tag_id[31:0];
        OFF_ID_HI: n.rdata = r.tag_id[63:32];
        OFF_FAMILY: n.rdata = {24'h00_0000, r.family};
        OFF_REQCNT: n.rdata = {16'h0000, r.req_cnt};
        default: begin
          n.rdata = 32'h0000_0000;
          n.rresp = RESP_SLVERR;
        end
      endcase
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      r <= '0;
      r.state <= RFTAG_OFF;
      r.ctrl_en <= CTRL_EN_RESET;
      r.tag_id <= TAG_ID_RESET;
      r.family <= FAMILY_RESET;
    end else begin
      r <= n;
    end
  end

  assign O_AWREADY = r.awready;
  assign O_WREADY = r.wready;
  assign O_BVALID = r.bvalid;
  assign O_BRESP = r.bresp;
  assign O_ARREADY = r.arready;
  assign O_RVALID = r.rvalid;
  assign O_RDATA = r.rdata;
  assign O_RRESP = r.rresp;
  assign O_STATE = r.state;
  assign O_RSP_VALID = r.rsp_valid;
  assign O_RSP_ANSWER = r.rsp_answer;
  assign O_RSP_ERROR = r.rsp_error;
  assign O_RSP_CODE = r.rsp_code;
  assign O_TWO_SUBCARRIERS = r.two_sub;
  assign O_HIGH_RATE = r.high_rate;
  assign O_EXTENDED = r.extended;
  assign O_RICH_SYSINFO = r.rich_info;
  assign O_FAMILY_PRESENT = r.fam_present;
  assign O_SINGLE_SLOT = r.single_slot;

  // ==========================================================
  // Checks
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RESET);

  logic req_ok;
  assign req_ok = I_REQ_VALID && r.field && I_REQ_CRC_OK && r.ctrl_en;

  AST_ONE_STATE: assert property ($onehot(r.state))
    else $error("state is not one-hot");
  AST_POWER_UP: assert property (r.state == RFTAG_OFF && r.field |=> r.state == RFTAG_READY)
    else $error("field present but tag stays off");
  AST_READY_GATE: assert property (req_ok && r.state == RFTAG_READY && !I_REQ_FLAGS[FLG_INVENTORY]
      && I_REQ_FLAGS[FLG_SELECT] && !I_REQ_FLAGS[FLG_ADDRESS] |=> r.rsp_valid && !r.rsp_answer)
    else $error("ready tag answered a select-mode request");
  AST_QUIET_INV: assert property (req_ok && r.state == RFTAG_QUIET && I_REQ_FLAGS[FLG_INVENTORY]
      && I_REQ_FLAGS[FLG_SLOTS] |=> !r.rsp_answer)
    else $error("quiet tag answered inventory");
  AST_SEL_ANSWER: assert property (req_ok && r.state == RFTAG_SELECTED && !I_REQ_FLAGS[FLG_INVENTORY]
      && I_REQ_FLAGS[FLG_SELECT] && !I_REQ_FLAGS[FLG_ADDRESS] |=> r.rsp_answer && !r.rsp_error)
    else $error("selected tag silent in select mode");
  AST_QUIET_GENERAL: assert property (req_ok && r.state == RFTAG_QUIET && !I_REQ_FLAGS[FLG_INVENTORY]
      && !I_REQ_FLAGS[FLG_SELECT] && !I_REQ_FLAGS[FLG_ADDRESS] |=> !r.rsp_answer)
    else $error("quiet tag answered a general request");
  AST_LOSS_OFF: assert property (!r.field && r.state != RFTAG_OFF && r.loss_cnt == LOSS_LAST
      |=> r.state == RFTAG_OFF)
    else $error("field-loss time elapsed but tag not off");
  AST_ID_MISS: assert property (req_ok && !I_REQ_FLAGS[FLG_INVENTORY] && I_REQ_FLAGS[FLG_ADDRESS]
      && !I_REQ_FLAGS[FLG_SELECT] && I_REQ_ID != r.tag_id |=> !r.rsp_answer)
    else $error("answer to a foreign serial id");
  AST_CRC_DROP: assert property (I_REQ_VALID && r.field && !I_REQ_CRC_OK
      |=> r.rsp_valid && !r.rsp_answer)
    else $error("answer to a request with bad CRC");
  AST_BOTH_BITS: assert property (req_ok && r.state != RFTAG_OFF && !I_REQ_FLAGS[FLG_INVENTORY]
      && I_REQ_FLAGS[FLG_SELECT] && I_REQ_FLAGS[FLG_ADDRESS]
      |=> r.rsp_answer && r.rsp_error && r.rsp_code == ERR_OPTION)
    else $error("missing option-unsupported error");
  AST_REPLY_FMT: assert property (I_REQ_VALID && r.field
      |=> r.two_sub == $past(I_REQ_FLAGS[FLG_SUBCARRIER]) && r.high_rate == $past(I_REQ_FLAGS[FLG_DATA_RATE])
      && r.extended == $past(I_REQ_FLAGS[FLG_EXTENSION]))
    else $error("reply format flags not taken");
  AST_SLOTS: assert property (I_REQ_VALID && r.field && I_REQ_FLAGS[FLG_INVENTORY]
      |=> r.single_slot == $past(I_REQ_FLAGS[FLG_SLOTS]))
    else $error("slot count flag not taken");

  CVR_SELECT: cover property (r.state == RFTAG_READY ##1 r.state == RFTAG_SELECTED);
  CVR_QUIET: cover property (r.state == RFTAG_QUIET && r.rsp_valid && r.rsp_answer);
  CVR_LOSS: cover property (r.state == RFTAG_SELECTED ##1 r.state == RFTAG_OFF);
  CVR_ERROR: cover property (r.rsp_valid && r.rsp_error);

endmodule : rftag_ctrl

`default_nettype wire

// ===== rftag_reader.sv
// Reader model: field energy and one-pulse framed requests into the tag.
// Assumes the tag samples request lines on the rising clock edge.
`timescale 1ns/100ps
`default_nettype none
module rftag_reader (
  input wire logic i_clk,
  output logic o_field_ok,
  output logic o_req_valid,
  output logic o_req_crc_ok,
  output logic [7:0] o_req_flags,
  output logic [7:0] o_req_cmd,
  output logic [63:0] o_req_id,
  output logic [7:0] o_req_family
);
  localparam logic [7:0] CMD_BLK_READ = 8'h20;
  initial begin
    o_field_ok = 1'b0;
    o_req_valid = 1'b0;
    o_req_crc_ok = 1'b0;
    o_req_flags = 8'h00;
    o_req_cmd = 8'h00;
    o_req_id = 64'h0;
    o_req_family = 8'h00;
  end
  task automatic set_field(input logic v);
    @(posedge i_clk);
    o_field_ok <= v;
  endtask : set_field
  // Lines not carrying a field show inverted data, never a stale value
  task automatic send(input logic [7:0] f, input logic [7:0] c, input logic [63:0] id, input logic crc,
                      input logic brk);
    logic [7:0] fl;
    fl = f;
    fl[7] = 1'b0;
    if (fl[4] && !fl[2] && !brk) fl[5] = 1'b0;
    if (c == CMD_BLK_READ) fl[3] = 1'b1;
    @(posedge i_clk);
    o_req_valid <= 1'b1;
    o_req_crc_ok <= crc;
    o_req_flags <= fl;
    o_req_cmd <= c;
    o_req_id <= (!fl[2] && fl[5]) ? id : ~id;
    o_req_family <= (fl[2] && fl[4]) ? 8'h00 : 8'hff;
    @(posedge i_clk);
    o_req_valid <= 1'b0;
    o_req_crc_ok <= ~crc;
    o_req_flags <= ~fl;
    o_req_cmd <= ~c;
    o_req_id <= ~id;
    o_req_family <= ~o_req_family;
  endtask : send
endmodule : rftag_reader
`default_nettype wire

// ===== rftag_ctrl_tb.sv
// Self-checking bench for the tag state machine and request-flag decoder.
// Assumes rftag_pkg and rftag_reader; register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module rftag_ctrl_tb;
  import rftag_pkg::*;
  localparam logic [63:0] TAG = 64'h5a5a_3c3c_0f0f_1234; // Arbitrary serial id
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic field_ok, req_valid, crc_ok;
  logic [7:0] flags, cmd, fam, awaddr, araddr, code, f, c;
  logic [63:0] rid;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, state;
  logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic rsp_valid, ans, err, two, high, ext, rich, famp, slot;
  int n_fail = 0;
  int cmp_count = 0;
  int seed = 56;
  int n_req = 0;
  logic [19:0] notes[$];
  // ==========================================================
  // Clock, design and reader
  always #10 sys_clk = ~sys_clk;
  rftag_ctrl #(.FIELD_LOSS_NS(200), .TAG_ID_RESET(TAG)) dut (
    .I_SYS_CLK(sys_clk), .I_RESET(rst), .I_FIELD_OK(field_ok), .I_REQ_VALID(req_valid),
    .I_REQ_CRC_OK(crc_ok), .I_REQ_FLAGS(flags), .I_REQ_CMD(cmd), .I_REQ_ID(rid), .I_REQ_FAMILY(fam),
    .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(wstrb),
    .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready),
    .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata), .O_RRESP(rresp),
    .O_RVALID(rvalid), .I_RREADY(rready), .O_STATE(state), .O_RSP_VALID(rsp_valid), .O_RSP_ANSWER(ans),
    .O_RSP_ERROR(err), .O_RSP_CODE(code), .O_TWO_SUBCARRIERS(two), .O_HIGH_RATE(high), .O_EXTENDED(ext),
    .O_RICH_SYSINFO(rich), .O_FAMILY_PRESENT(famp), .O_SINGLE_SLOT(slot));
  rftag_reader reader (.i_clk(sys_clk), .o_field_ok(field_ok), .o_req_valid(req_valid), .o_req_crc_ok(crc_ok),
    .o_req_flags(flags), .o_req_cmd(cmd), .o_req_id(rid), .o_req_family(fam));
  // ==========================================================
  // Checking and closing
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  always @(negedge sys_clk) begin
    if (rsp_valid === 1'b1) begin
      if (notes.size() == 0) check(32'h1, 32'h0);
      else check({state, ans, err, code, two, high, ext, rich, famp, slot}, notes.pop_front());
    end
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_fail++;
    give_verdict();
  end
  // ==========================================================
  // Drivers
  task automatic req(input logic [7:0] rf, input logic [7:0] rc, input logic [63:0] id, input logic crc,
                     input logic [3:0] exp_state, input logic a, input logic e);
    n_req++;
    notes.push_back({exp_state, a, e, e ? ERR_OPTION : 8'h00, rf[0], rf[1], rf[3], (rc == CMD_SYSINFO) && rf[3],
                     rf[2] && rf[4], rf[2] && rf[5]});
    reader.send(rf, rc, id, crc, rf[4] && rf[5] && !rf[2]);
  endtask : req
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge sys_clk);
      if (awready === 1'b1) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge sys_clk);
    bready <= 1'b0;
    check(bresp, RESP_OKAY);
  endtask : axw
  task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge sys_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge sys_clk);
    rready <= 1'b0;
    check({rresp, rdata}, {r, d});
  endtask : axr
  // ==========================================================
  // Scenarios
  initial begin
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hf;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    check(state, RFTAG_OFF);
    axr(OFF_CTRL, 32'h1, RESP_OKAY);
    reader.set_field(1'b1);
    repeat (6) @(posedge sys_clk);
    axr(OFF_STATUS, 32'h12, RESP_OKAY);
    axr(8'h20, 32'h0, RESP_SLVERR);
    axr(OFF_ID_HI, TAG[63:32], RESP_OKAY);
    // Family register differs from the code the reader sends, so inventory stays silent
    axw(OFF_FAMILY, 32'h0000_005a);
    axr(OFF_FAMILY, 32'h0000_005a, RESP_OKAY);
    req(8'h14, 8'h01, TAG, 1'b1, RFTAG_READY, 1'b0, 1'b0);
    axw(OFF_FAMILY, 32'h0000_0000);
    req(8'h00, 8'h30, TAG, 1'b1, RFTAG_READY, 1'b1, 1'b0);
    req(8'h10, 8'h30, TAG, 1'b1, RFTAG_READY, 1'b0, 1'b0);
    req(8'h20, 8'h30, TAG ^ 64'h1, 1'b1, RFTAG_READY, 1'b0, 1'b0);
    req(8'h20, 8'h30, TAG, 1'b1, RFTAG_READY, 1'b1, 1'b0);
    req(8'h30, 8'h30, TAG, 1'b1, RFTAG_READY, 1'b1, 1'b1);
    req(8'h00, 8'h30, TAG, 1'b0, RFTAG_READY, 1'b0, 1'b0);
    repeat (8) begin
      f = 8'($random(seed)) & 8'h8b;
      c = ($random(seed) & 1) ? CMD_SYSINFO : 8'h30;
      req(f, c, TAG, 1'b1, RFTAG_READY, 1'b1, 1'b0);
    end
    req(8'h20, CMD_STAY_QUIET, TAG, 1'b1, RFTAG_QUIET, 1'b1, 1'b0);
    req(8'h00, 8'h30, TAG, 1'b1, RFTAG_QUIET, 1'b0, 1'b0);
    req(8'h24, 8'h01, TAG, 1'b1, RFTAG_QUIET, 1'b0, 1'b0);
    req(8'h14, 8'h01, TAG, 1'b1, RFTAG_QUIET, 1'b1, 1'b0);
    req(8'h04, 8'h01, TAG, 1'b1, RFTAG_QUIET, 1'b1, 1'b0);
    req(8'h20, 8'h30, TAG, 1'b1, RFTAG_QUIET, 1'b1, 1'b0);
    req(8'h20, CMD_SELECT, TAG, 1'b1, RFTAG_SELECTED, 1'b1, 1'b0);
    req(8'h10, 8'h30, TAG, 1'b1, RFTAG_SELECTED, 1'b1, 1'b0);
    req(8'h00, 8'h30, TAG, 1'b1, RFTAG_SELECTED, 1'b1, 1'b0);
    req(8'h20, 8'h30, ~TAG, 1'b1, RFTAG_SELECTED, 1'b0, 1'b0);
    req(8'h00, CMD_RESET_READY, TAG, 1'b1, RFTAG_READY, 1'b1, 1'b0);
    axw(OFF_CTRL, 32'h0);
    req(8'h00, 8'h30, TAG, 1'b1, RFTAG_READY, 1'b0, 1'b0);
    axw(OFF_CTRL, 32'h1);
    // A short loss of field keeps the state; requests meanwhile get no pulse
    reader.set_field(1'b0);
    repeat (5) @(posedge sys_clk);
    check(state, RFTAG_READY);
    reader.send(8'h00, 8'h30, TAG, 1'b1, 1'b0);
    repeat (12) @(posedge sys_clk);
    check(state, RFTAG_OFF);
    reader.set_field(1'b1);
    repeat (6) @(posedge sys_clk);
    check(state, RFTAG_READY);
    repeat (3) @(posedge sys_clk);
    axr(OFF_REQCNT, n_req, RESP_OKAY);
    check(notes.size(), 32'h0);
    give_verdict();
  end
endmodule : rftag_ctrl_tb
`default_nettype wire
